/* rtl/bobe_pkg.sv */
// package: constants, opcode patterns and state type of the bit/branch/call executor
package bobe_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int INSTR_W = 14;
  localparam int FILE_AW = 7;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // instruction field positions
  // ------------------------------------------------------------
  localparam int FILE_LSB = 0;
  localparam int BIT_LSB = 7;
  localparam int REL_K_W = 9;
  localparam int CALL_K_W = 11;
  localparam int LATCH_HI_MSB = 6;
  localparam int LATCH_HI_LSB = 3;

  // ------------------------------------------------------------
  // opcode masks and match values
  // ------------------------------------------------------------
  localparam logic [13:0] BITOP_MASK = 14'h3C00;
  localparam logic [13:0] BIT_CLEAR_VAL = 14'h1000;
  localparam logic [13:0] BIT_SET_VAL = 14'h1400;
  localparam logic [13:0] SKIP_CLEAR_VAL = 14'h1800;
  localparam logic [13:0] SKIP_SET_VAL = 14'h1C00;
  localparam logic [13:0] CALL_MASK = 14'h3800;
  localparam logic [13:0] CALL_VAL = 14'h2000;
  localparam logic [13:0] REL_MASK = 14'h3E00;
  localparam logic [13:0] REL_VAL = 14'h3200;
  localparam logic [13:0] ACC_BR_VAL = 14'h000B;

  // ------------------------------------------------------------
  // reset value and increment
  // ------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;

  typedef enum logic [6:0] {
    BOBE_OP_NONE = 7'h01,
    BOBE_OP_BIT_CLEAR = 7'h02,
    BOBE_OP_BIT_SET = 7'h04,
    BOBE_OP_SKIP_CLEAR = 7'h08,
    BOBE_OP_SKIP_SET = 7'h10,
    BOBE_OP_REL_BRANCH = 7'h20,
    BOBE_OP_ACC_BRANCH = 7'h40
  } bobe_op_t;

  typedef struct packed {
    logic flush;
    logic pc_load;
    logic [PC_W-1:0] pc_target;
    logic push;
    logic [PC_W-1:0] push_data;
    logic file_we;
    logic [FILE_AW-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata;
  } bobe_state_t;

  localparam bobe_state_t STATE_RESET = '0;

endpackage

/* rtl/bobe_bit_if.sv */
// interface: operand and result between executor and bit unit
`timescale 1ns/1ps
`default_nettype none
interface bobe_bit_if;
  logic [7:0] operand;
  logic [2:0] index;
  logic set;
  logic [7:0] result;
  logic tested;
  modport exec (output operand, output index, output set, input result, input tested);
  modport unit (input operand, input index, input set, output result, output tested);
endinterface
`default_nettype wire

/* rtl/bobe_bit_unit.sv */
// module: single-bit modify and test on one file register value
`timescale 1ns/1ps
`default_nettype none
module bobe_bit_unit (
  bobe_bit_if.unit bif
);
  logic [7:0] mask;

  always_comb begin
    mask = 8'h01 << bif.index;
    // other bits pass through untouched
    bif.result = bif.set ? (bif.operand | mask) : (bif.operand & ~mask);
    bif.tested = |(bif.operand & mask);
  end
endmodule
`default_nettype wire

/* rtl/bobe_exec.sv */
// module: executor for bit clear/set, bit-test skips, relative branches and call
// Behaviour
// - bit_clear_op zeroes bit b of file register f, keeps other bits, leaves flags alone.
// - bit_set_op sets bit b of file register f, keeps other bits, leaves flags alone.
// - relative_branch_op loads PC with PC+1 plus the sign-extended 9-bit offset, no flags.
// - relative_branch_op takes two cycles since the fetched next word is flushed.
// - branch_by_accumulator_op loads PC with PC+1 plus unsigned W in two cycles, no flags.
// - skip_if_bit_clear_op discards the next word as a no-op when the bit is zero.
// - skip_if_bit_set_op discards the next word as a no-op when the bit is one.
// - the bit-test skips modify no status flag either way.
// - call pushes PC+1 to return_stack_top then loads its 11-bit operand into PC[10:0].
// - call fills PC[14:11] from pc_high_latch bits 6 down to 3.
// - call takes two cycles and leaves all flags unchanged.
`timescale 1ns/1ps
`default_nettype none
module bobe_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [14:0] pc_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] pc_high_latch_i,
  input wire logic [7:0] file_rdata_i,
  output logic [6:0] file_raddr_o,
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  output logic pc_load_o,
  output logic [14:0] pc_target_o,
  output logic stack_push_o,
  output logic [14:0] return_stack_top_o,
  output logic discard_o,
  output logic handled_o
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic bobe_pkg::bobe_op_t decode(input logic [13:0] w);
    bobe_pkg::bobe_op_t op;
    op = bobe_pkg::BOBE_OP_NONE;
    if ((w & bobe_pkg::BITOP_MASK) == bobe_pkg::BIT_CLEAR_VAL) op = bobe_pkg::BOBE_OP_BIT_CLEAR;
    if ((w & bobe_pkg::BITOP_MASK) == bobe_pkg::BIT_SET_VAL) op = bobe_pkg::BOBE_OP_BIT_SET;
    if ((w & bobe_pkg::BITOP_MASK) == bobe_pkg::SKIP_CLEAR_VAL) op = bobe_pkg::BOBE_OP_SKIP_CLEAR;
    if ((w & bobe_pkg::BITOP_MASK) == bobe_pkg::SKIP_SET_VAL) op = bobe_pkg::BOBE_OP_SKIP_SET;
    if ((w & bobe_pkg::REL_MASK) == bobe_pkg::REL_VAL) op = bobe_pkg::BOBE_OP_REL_BRANCH;
    if (w == bobe_pkg::ACC_BR_VAL) op = bobe_pkg::BOBE_OP_ACC_BRANCH;
    return op;
  endfunction

  bobe_pkg::bobe_state_t cur;
  bobe_pkg::bobe_state_t next_cur;
  bobe_pkg::bobe_op_t op;
  logic live;
  logic is_call;
  logic [14:0] pc_inc;
  logic [14:0] rel_off;
  bobe_bit_if bif ();

  bobe_bit_unit u_bit (
    .bif(bif)
  );

  // ------------------------------------------------------------
  // combinational next state
  // ------------------------------------------------------------
  always_comb begin
    // a word arriving in the flush cycle is the discarded one
    live = instr_valid_i && !cur.flush;
    op = decode(instr_i);
    is_call = (instr_i & bobe_pkg::CALL_MASK) == bobe_pkg::CALL_VAL;
    pc_inc = pc_i + bobe_pkg::PC_ONE;
    rel_off = {{(bobe_pkg::PC_W - bobe_pkg::REL_K_W){instr_i[8]}}, instr_i[8:0]};
    bif.operand = file_rdata_i;
    bif.index = instr_i[bobe_pkg::BIT_LSB +: 3];
    bif.set = (op == bobe_pkg::BOBE_OP_BIT_SET);
    file_raddr_o = instr_i[bobe_pkg::FILE_LSB +: bobe_pkg::FILE_AW];
    handled_o = live && ((op != bobe_pkg::BOBE_OP_NONE) || is_call);
    // no status write path exists here: flags stay as they are
    next_cur = bobe_pkg::STATE_RESET;
    if (live && is_call) begin
      next_cur.push = 1'b1;
      next_cur.push_data = pc_inc;
      next_cur.pc_load = 1'b1;
      next_cur.pc_target = {pc_high_latch_i[bobe_pkg::LATCH_HI_MSB:bobe_pkg::LATCH_HI_LSB],
                            instr_i[bobe_pkg::CALL_K_W-1:0]};
      next_cur.flush = 1'b1;
    end else if (live) begin
      unique case (op)
        bobe_pkg::BOBE_OP_BIT_CLEAR, bobe_pkg::BOBE_OP_BIT_SET: begin
          next_cur.file_we = 1'b1;
          next_cur.file_waddr = file_raddr_o;
          next_cur.file_wdata = bif.result;
        end
        bobe_pkg::BOBE_OP_SKIP_CLEAR: begin
          next_cur.flush = !bif.tested;
        end
        bobe_pkg::BOBE_OP_SKIP_SET: begin
          next_cur.flush = bif.tested;
        end
        bobe_pkg::BOBE_OP_REL_BRANCH: begin
          next_cur.pc_load = 1'b1;
          next_cur.pc_target = pc_inc + rel_off;
          next_cur.flush = 1'b1;
        end
        bobe_pkg::BOBE_OP_ACC_BRANCH: begin
          next_cur.pc_load = 1'b1;
          next_cur.pc_target = pc_inc + {7'h00, acc_i};
          next_cur.flush = 1'b1;
        end
        bobe_pkg::BOBE_OP_NONE: begin
          next_cur.flush = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= bobe_pkg::STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign file_we_o = cur.file_we;
  assign file_waddr_o = cur.file_waddr;
  assign file_wdata_o = cur.file_wdata;
  assign pc_load_o = cur.pc_load;
  assign pc_target_o = cur.pc_target;
  assign stack_push_o = cur.push;
  assign return_stack_top_o = cur.push_data;
  assign discard_o = cur.flush;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BIT_CLEAR: assert property (
    live && op == bobe_pkg::BOBE_OP_BIT_CLEAR && !is_call
    |=> file_we_o && file_waddr_o == $past(instr_i[6:0])
        && file_wdata_o == ($past(file_rdata_i) & ~(8'h01 << $past(instr_i[9:7]))))
    else $error("bit clear result wrong");
  AST_BIT_SET: assert property (
    live && op == bobe_pkg::BOBE_OP_BIT_SET && !is_call
    |=> file_we_o && file_waddr_o == $past(instr_i[6:0])
        && file_wdata_o == ($past(file_rdata_i) | (8'h01 << $past(instr_i[9:7]))))
    else $error("bit set result wrong");
  // a bit op is single cycle: nothing may touch program flow
  AST_BIT_NO_JUMP: assert property (
    live && !is_call
    && (op == bobe_pkg::BOBE_OP_BIT_CLEAR || op == bobe_pkg::BOBE_OP_BIT_SET)
    |=> !pc_load_o && !stack_push_o && !discard_o)
    else $error("bit op disturbed program flow");

  AST_REL_TARGET: assert property (
    live && op == bobe_pkg::BOBE_OP_REL_BRANCH && !is_call
    |=> pc_load_o && !stack_push_o && !file_we_o
        && pc_target_o == 15'($past(pc_i) + 15'h0001
        + {{6{$past(instr_i[8])}}, $past(instr_i[8:0])}))
    else $error("relative branch target wrong");
  AST_REL_TWO_CYCLE: assert property (
    live && op == bobe_pkg::BOBE_OP_REL_BRANCH && !is_call
    |=> discard_o ##1 !discard_o && !pc_load_o)
    else $error("relative branch not two cycles");
  AST_ACC_TARGET: assert property (
    live && op == bobe_pkg::BOBE_OP_ACC_BRANCH
    |=> pc_load_o && discard_o && !stack_push_o && !file_we_o
        && pc_target_o == 15'($past(pc_i) + 15'h0001 + {7'h00, $past(acc_i)}))
    else $error("accumulator branch wrong");

  // expected skip taken from the raw read data, not from the bit unit
  AST_SKIP_CLEAR: assert property (
    live && op == bobe_pkg::BOBE_OP_SKIP_CLEAR && !is_call
    |=> discard_o == !$past(file_rdata_i[instr_i[9:7]]) && !pc_load_o)
    else $error("skip if clear wrong");
  AST_SKIP_SET: assert property (
    live && op == bobe_pkg::BOBE_OP_SKIP_SET && !is_call
    |=> discard_o == $past(file_rdata_i[instr_i[9:7]]) && !pc_load_o)
    else $error("skip if set wrong");
  AST_SKIP_NO_WRITE: assert property (
    live && !is_call
    && (op == bobe_pkg::BOBE_OP_SKIP_CLEAR || op == bobe_pkg::BOBE_OP_SKIP_SET)
    |=> !file_we_o && !stack_push_o)
    else $error("skip wrote state");

  AST_CALL_PUSH: assert property (
    live && is_call
    |=> stack_push_o && return_stack_top_o == 15'($past(pc_i) + 15'h0001)
        && pc_target_o[10:0] == $past(instr_i[10:0]))
    else $error("call push or low target wrong");
  AST_CALL_DECODE: assert property (
    instr_valid_i && !discard_o && (instr_i & bobe_pkg::CALL_MASK) == bobe_pkg::CALL_VAL
    |-> handled_o)
    else $error("call word not taken");
  AST_CALL_HIGH: assert property (
    live && is_call
    |=> pc_target_o[14:11] == $past(pc_high_latch_i[6:3]))
    else $error("call high target wrong");
  AST_CALL_TWO_CYCLE: assert property (
    live && is_call
    |=> pc_load_o && discard_o && !file_we_o ##1 !discard_o && !stack_push_o)
    else $error("call not two cycles");

  // only one stale word may die per two-cycle instruction
  AST_ONE_FLUSH: assert property (
    discard_o |=> !discard_o && !pc_load_o && !file_we_o)
    else $error("more than one flushed cycle");
  // the word shown in the flush cycle is the stale fetch and must stay dead
  AST_FLUSH_DEAD: assert property (
    discard_o |-> !handled_o)
    else $error("word accepted in flush cycle");
  // unknown words and idle cycles must leave every pulse low
  AST_QUIET_IDLE: assert property (
    !handled_o |=> !file_we_o && !pc_load_o && !stack_push_o && !discard_o)
    else $error("output pulse without an instruction");

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  COV_CALL: cover property (live && is_call ##1 stack_push_o);
  COV_SKIP_TAKEN: cover property (live && op == bobe_pkg::BOBE_OP_SKIP_SET ##1 discard_o);
  COV_BACKWARD_REL: cover property (live && op == bobe_pkg::BOBE_OP_REL_BRANCH && instr_i[8]);
  COV_BIT_WRITE: cover property (live && op == bobe_pkg::BOBE_OP_BIT_CLEAR ##1 file_we_o);
  COV_ACC_BRANCH: cover property (live && op == bobe_pkg::BOBE_OP_ACC_BRANCH ##1 pc_load_o);
endmodule
`default_nettype wire

/* verif/bobe_file_model.sv */
// model: data register file on the far side of the executor
`timescale 1ns/1ps
`default_nettype none
module bobe_file_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [128];
  // read is combinational: the executor samples it in the execute cycle
  assign rdata_o = mem[raddr_i];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 128; i++) begin
        mem[i] <= 8'hA5;
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// testbench: directed scenarios for the bit/branch/call executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [14:0] pc_i = 15'h0000;
  logic [7:0] acc_i = 8'h00;
  logic [7:0] pc_high_latch_i = 8'h00;
  logic [7:0] file_rdata, file_wdata;
  logic [6:0] file_raddr, file_waddr;
  logic [14:0] pc_target, stack_top;
  logic file_we, pc_load, stack_push, discard, handled;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] sh [128];
  wire [48:0] outs = {file_we, file_waddr, file_wdata, pc_load, pc_target, stack_push, stack_top,
    discard};
  bobe_exec u_bobe_exec (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_i(pc_i), .acc_i(acc_i), .pc_high_latch_i(pc_high_latch_i),
    .file_rdata_i(file_rdata), .file_raddr_o(file_raddr), .file_we_o(file_we),
    .file_waddr_o(file_waddr), .file_wdata_o(file_wdata), .pc_load_o(pc_load),
    .pc_target_o(pc_target), .stack_push_o(stack_push), .return_stack_top_o(stack_top),
    .discard_o(discard), .handled_o(handled));
  bobe_file_model u_bobe_file_model (.clk_i(clk_i), .rst_i(rst_i), .raddr_i(file_raddr),
    .rdata_o(file_rdata), .we_i(file_we), .waddr_i(file_waddr), .wdata_i(file_wdata));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [48:0] seen, input logic [48:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [13:0] bw(input logic [13:0] base, input int b, input logic [6:0] f);
    return base | 14'(b << 7) | {7'h00, f};
  endfunction
  function automatic logic [48:0] wr(input logic [6:0] f, input logic [7:0] v);
    return {1'b1, f, v, 33'h0};
  endfunction
  function automatic logic [48:0] jmp(input logic [14:0] t, input logic sp, input logic [14:0] r);
    return {16'h0, 1'b1, t, sp, r, 1'b1};
  endfunction
  // word w, then word nw back to back; e1 and e2 are the pulses each cycle after
  task automatic ex(input logic [13:0] w, input logic [14:0] pc, input logic [48:0] e1,
    input logic [13:0] nw, input logic [48:0] e2);
    @(negedge clk_i);
    instr_valid_i = 1'b1;
    instr_i = w;
    pc_i = pc;
    #1 chk({41'h0, handled, file_raddr}, {41'h0, 1'b1, w[6:0]});
    @(negedge clk_i);
    chk(outs, e1);
    instr_i = nw;
    pc_i = pc + 15'h0001;
    // a word shown while the last one is being discarded must not be taken
    #1 chk({48'h0, handled}, {48'h0, !e1[0] && nw != 14'h0000});
    @(negedge clk_i);
    chk(outs, e2);
    instr_valid_i = 1'b0;
  endtask
  task automatic t_bit_ops();
    logic [6:0] f;
    logic [7:0] v;
    for (int b = 0; b < 8; b++) begin
      f = 7'(b * 18 + 1);
      v = sh[f] & ~(8'h01 << b);
      ex(bw(14'h1000, b, f), 15'h0100, wr(f, v), 14'h0000, '0);
      v = v | (8'h01 << b);
      ex(bw(14'h1400, b, f), 15'h0100, wr(f, v), 14'h0000, '0);
      sh[f] = v;
    end
  endtask
  task automatic t_skips();
    logic [6:0] f;
    f = 7'h10;
    ex(bw(14'h1800, 3, f), 15'h0040, 49'h1, bw(14'h1400, 3, f), '0);
    ex(bw(14'h1C00, 3, f), 15'h0040, '0, bw(14'h1400, 3, f), wr(f, sh[f] | 8'h08));
    sh[f] = sh[f] | 8'h08;
    ex(bw(14'h1C00, 3, f), 15'h0040, 49'h1, bw(14'h1000, 3, f), '0);
    ex(bw(14'h1800, 3, f), 15'h0040, '0, bw(14'h1000, 3, f), wr(f, sh[f] & 8'hF7));
  endtask
  task automatic t_branches();
    logic [8:0] k [2] = '{9'h0FF, 9'h100};
    logic [14:0] p [2] = '{15'h7FF0, 15'h0010};
    logic [14:0] t;
    for (int i = 0; i < 2; i++) begin
      t = p[i] + 15'h0001 + {{6{k[i][8]}}, k[i]};
      ex(14'h3200 | {5'h00, k[i]}, p[i], jmp(t, 1'b0, 15'h0), 14'h1401, '0);
      acc_i = k[i][7:0] ^ 8'h80;
      t = p[i] + 15'h0001 + {7'h00, acc_i};
      ex(14'h000B, p[i], jmp(t, 1'b0, 15'h0), 14'h1401, '0);
    end
  endtask
  task automatic t_call();
    logic [7:0] l [2] = '{8'h87, 8'h78};
    logic [10:0] k [2] = '{11'h7FF, 11'h000};
    logic [14:0] p [2] = '{15'h1234, 15'h7FFF};
    for (int i = 0; i < 2; i++) begin
      pc_high_latch_i = l[i];
      ex(14'h2000 | {3'h0, k[i]}, p[i], jmp({l[i][6:3], k[i]}, 1'b1, p[i] + 15'h0001),
        14'h1401, '0);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 128; i++) begin
      sh[i] = 8'hA5;
    end
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    fork
      begin
        t_bit_ops();
        t_skips();
        t_branches();
        t_call();
      end
      begin
        // cut a hang short well past the roughly 80 cycles the scenarios need
        while (cyc < 2000) begin
          @(posedge clk_i);
          cyc++;
        end
        mismatches++;
      end
    join_any
    stop_test();
  end
endmodule
`default_nettype wire
